// ### logic/iarao_pkg.sv
// package: constants and types of the input-read and accumulator command block
package iarao_pkg;
  localparam logic [7:0]  IARAO_INSTR_GET_INPUT  = 8'h0F;
  localparam logic [7:0]  IARAO_INSTR_ARITH      = 8'h13;
  localparam logic [7:0]  IARAO_INSTR_COMPARE    = 8'h14;
  localparam logic [7:0]  IARAO_STATUS_OK        = 8'h64;
  localparam logic [7:0]  IARAO_STATUS_BAD_CMD   = 8'h02;
  localparam logic [7:0]  IARAO_STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0]  IARAO_BANK_DIGITAL     = 8'h00;
  localparam logic [7:0]  IARAO_BANK_ANALOG      = 8'h01;
  localparam logic [7:0]  IARAO_BANK_OUTPUTS     = 8'h02;
  localparam logic [7:0]  IARAO_PORT_ZERO        = 8'h00;
  localparam logic [7:0]  IARAO_PORT_ONE         = 8'h01;
  localparam logic [7:0]  IARAO_PORT_TWO         = 8'h02;
  localparam logic [7:0]  IARAO_PORT_SUPPLY      = 8'h08;
  localparam logic [7:0]  IARAO_PORT_TEMP        = 8'h09;
  localparam logic [7:0]  IARAO_PORT_ALL_INPUTS  = 8'hFF;
  localparam logic [31:0] IARAO_ANALOG_MAX       = 32'h0000_0FFF;
  localparam logic [31:0] IARAO_ACC_RESET        = 32'h0000_0000;
  localparam logic [3:0]  IARAO_LAST_BYTE        = 4'h8;
  localparam logic [3:0]  IARAO_FIRST_BYTE       = 4'h0;
  localparam int          IARAO_FRAME_BYTES      = 9;
  localparam int          IARAO_NUM_INPUTS       = 3;

  typedef enum logic [3:0] {
    IARAO_OP_ADD  = 4'h0,
    IARAO_OP_SUB  = 4'h1,
    IARAO_OP_MUL  = 4'h2,
    IARAO_OP_DIV  = 4'h3,
    IARAO_OP_MOD  = 4'h4,
    IARAO_OP_AND  = 4'h5,
    IARAO_OP_OR   = 4'h6,
    IARAO_OP_XOR  = 4'h7,
    IARAO_OP_NOT  = 4'h8,
    IARAO_OP_LOAD = 4'h9
  } iarao_op_type;

  typedef enum logic [1:0] {
    IARAO_ST_IDLE = 2'b00,
    IARAO_ST_EXEC = 2'b01,
    IARAO_ST_SEND = 2'b10
  } iarao_state_type;

  typedef struct packed {
    logic [7:0]  host_addr;
    logic [7:0]  target_addr;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
    logic        from_program;
  } iarao_cmd_type;

  typedef struct packed {
    logic zero;
    logic equal;
    logic greater;
    logic lower;
  } iarao_flags_type;
endpackage

// ### logic/iarao_alu.sv
// accumulator arithmetic unit, combinational
module iarao_alu (
  // operands
  input  wire logic [31:0]            acc_in,
  input  wire logic [31:0]            operand_in,
  input  wire iarao_pkg::iarao_op_type op_in,
  // result
  output logic      [31:0]            result_out,
  output logic                        ok_out
);
  import iarao_pkg::*;

  logic signed [31:0] acc_s;
  logic signed [31:0] opd_s;
  logic signed [63:0] prod;

  assign acc_s = acc_in;
  assign opd_s = operand_in;
  assign prod  = acc_s * opd_s;

  always_comb begin
    result_out = acc_in;
    ok_out     = 1'b1;
    unique case (op_in)
      IARAO_OP_ADD:  result_out = acc_in + operand_in;
      IARAO_OP_SUB:  result_out = acc_in - operand_in;
      IARAO_OP_MUL:  result_out = prod[31:0];
      IARAO_OP_DIV: begin
        ok_out     = (operand_in != 32'h0000_0000);
        result_out = ok_out ? 32'(acc_s / opd_s) : acc_in;
      end
      IARAO_OP_MOD: begin
        ok_out     = (operand_in != 32'h0000_0000);
        result_out = ok_out ? 32'(acc_s % opd_s) : acc_in;
      end
      IARAO_OP_AND:  result_out = acc_in & operand_in;
      IARAO_OP_OR:   result_out = acc_in | operand_in;
      IARAO_OP_XOR:  result_out = acc_in ^ operand_in;
      IARAO_OP_NOT:  result_out = ~acc_in;
      IARAO_OP_LOAD: result_out = operand_in;
      default: begin
        ok_out     = 1'b0;
        result_out = acc_in;
      end
    endcase
  end
endmodule

// ### logic/iarao_core.sv
// command executor: input read, accumulator arithmetic, compare, reply frames
// Functional notes
// - get-input (code 15) reads the port given by the type byte in the bank given by the bank byte (0, 1 or 2).
// - digital reads of ports 0 to 2 return 0 or 1 and analog port 0 returns an unsigned 12-bit value 0 to 4095.
// - get-input run from program memory copies the read value into the accumulator.
// - get-input from the host in direct mode returns the value in the reply only and leaves the accumulator alone, unless it reads bank 0 port 255.
// - a good direct get-input is answered with status 100 and the port state as value.
// - bank 0 ports 0, 1, 2 return the digital state of general inputs zero, one and two.
// - bank 0 port 255 samples all general inputs at once and loads them into the accumulator as a bit vector.
// - bank 1 port 0 gives the analog value of input zero, port 8 supply in tenths of a volt, port 9 temperature.
// - bank 2 port 0 returns the driven state of general output zero as given on general_output_zero_in.
// - arithmetic (code 19) applies the type-selected operation to accumulator and operand and stores the result.
// - operations are 0 add, 1 sub, 2 mul, 3 div, 4 mod, 5 and, 6 or, 7 xor, 8 invert, 9 load.
// - a direct arithmetic command is answered with status 100 (4 for an op above 9 or a zero divisor) and the received operand as value.
// - compare (code 20) compares accumulator with operand and sets the flags for a later conditional jump.
module iarao_core (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  // command in
  input  wire logic                         cmd_valid_in,
  input  wire iarao_pkg::iarao_cmd_type     cmd_in,
  output logic                              cmd_ready_out,
  // sensed values
  input  wire logic [2:0]                   gen_inputs_in,
  input  wire logic [11:0]                  analog_zero_in,
  input  wire logic [15:0]                  supply_tenths_in,
  input  wire logic signed [15:0]           temperature_in,
  input  wire logic                         general_output_zero_in,
  // reply out
  output logic                              reply_valid_out,
  output logic [7:0]                        reply_byte_out,
  input  wire logic                         reply_ready_in,
  // program-mode results
  output logic                              prog_done_out,
  output logic [31:0]                       acc_out,
  output iarao_pkg::iarao_flags_type        flags_out
);
  import iarao_pkg::*;

  iarao_state_type state_r;
  iarao_cmd_type   cmd_r;
  logic [31:0]     acc_r;
  iarao_flags_type flags_r;
  logic [2:0]      gin_meta_r;
  logic [2:0]      gin_sync_r;
  logic [7:0]      frame_r [IARAO_FRAME_BYTES];
  logic [3:0]      idx_r;
  logic            cmd_ready_r;
  logic            reply_valid_r;
  logic [7:0]      reply_byte_r;
  logic            prog_done_r;
  logic [31:0]     read_val;
  logic            read_ok;
  logic [31:0]     alu_result;
  logic            alu_ok;
  logic            exec_gio;
  logic            exec_arith;
  logic            exec_cmp;
  logic [7:0]      status_nxt;
  logic [31:0]     value_nxt;
  logic [7:0]      chk;

  function automatic logic [7:0] sum_bytes(input logic [7:0] b [IARAO_FRAME_BYTES]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < IARAO_FRAME_BYTES - 1; i++) begin
      s = s + b[i];
    end
    return s;
  endfunction

  // input synchroniser
  always_ff @(posedge clk_in) begin
    gin_meta_r <= gen_inputs_in;
    gin_sync_r <= gin_meta_r;
  end

  assign exec_gio   = (state_r == IARAO_ST_EXEC) && (cmd_r.instr == IARAO_INSTR_GET_INPUT);
  assign exec_arith = (state_r == IARAO_ST_EXEC) && (cmd_r.instr == IARAO_INSTR_ARITH);
  assign exec_cmp   = (state_r == IARAO_ST_EXEC) && (cmd_r.instr == IARAO_INSTR_COMPARE);

  // port decode
  always_comb begin
    read_val = 32'h0000_0000;
    read_ok  = 1'b1;
    unique case (cmd_r.bank)
      IARAO_BANK_DIGITAL: begin
        if (cmd_r.typ == IARAO_PORT_ALL_INPUTS) begin
          read_val = {29'h0000_0000, gin_sync_r};
        end else if (cmd_r.typ <= IARAO_PORT_TWO) begin
          read_val = {31'h0000_0000, gin_sync_r[cmd_r.typ[1:0]]};
        end else begin
          read_ok = 1'b0;
        end
      end
      IARAO_BANK_ANALOG: begin
        if (cmd_r.typ == IARAO_PORT_ZERO) begin
          read_val = {20'h0_0000, analog_zero_in};
        end else if (cmd_r.typ == IARAO_PORT_SUPPLY) begin
          read_val = {16'h0000, supply_tenths_in};
        end else if (cmd_r.typ == IARAO_PORT_TEMP) begin
          read_val = {{16{temperature_in[15]}}, temperature_in};
        end else begin
          read_ok = 1'b0;
        end
      end
      IARAO_BANK_OUTPUTS: begin
        read_ok  = (cmd_r.typ == IARAO_PORT_ZERO);
        read_val = {31'h0000_0000, general_output_zero_in & read_ok};
      end
      default: read_ok = 1'b0;
    endcase
  end

  iarao_alu u_alu (
    .acc_in     (acc_r),
    .operand_in (cmd_r.value),
    .op_in      (iarao_op_type'(cmd_r.typ[3:0])),
    .result_out (alu_result),
    .ok_out     (alu_ok)
  );

  // reply status and value
  always_comb begin
    status_nxt = IARAO_STATUS_OK;
    value_nxt  = cmd_r.value;
    if (exec_gio) begin
      status_nxt = read_ok ? IARAO_STATUS_OK : IARAO_STATUS_BAD_VALUE;
      value_nxt  = read_val;
    end else if (exec_arith) begin
      status_nxt = (cmd_r.typ <= 8'h09 && alu_ok) ? IARAO_STATUS_OK : IARAO_STATUS_BAD_VALUE;
    end else if (!exec_cmp) begin
      status_nxt = IARAO_STATUS_BAD_CMD;
    end
  end

  // sequencing
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r     <= IARAO_ST_IDLE;
      cmd_r       <= '0;
      cmd_ready_r <= 1'b1;
      prog_done_r <= 1'b0;
    end else begin
      prog_done_r <= 1'b0;
      unique case (state_r)
        IARAO_ST_IDLE: begin
          if (cmd_valid_in) begin
            cmd_r       <= cmd_in;
            cmd_ready_r <= 1'b0;
            state_r     <= IARAO_ST_EXEC;
          end
        end
        IARAO_ST_EXEC: begin
          if (cmd_r.from_program) begin
            prog_done_r <= 1'b1;
            cmd_ready_r <= 1'b1;
            state_r     <= IARAO_ST_IDLE;
          end else begin
            state_r     <= IARAO_ST_SEND;
          end
        end
        IARAO_ST_SEND: begin
          if (reply_ready_in && idx_r == IARAO_LAST_BYTE) begin
            cmd_ready_r <= 1'b1;
            state_r     <= IARAO_ST_IDLE;
          end
        end
        default: state_r <= IARAO_ST_IDLE;
      endcase
    end
  end

  // accumulator
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_r <= IARAO_ACC_RESET;
    end else if (exec_gio && read_ok && cmd_r.from_program) begin
      acc_r <= read_val;
    end else if (exec_gio && read_ok && cmd_r.typ == IARAO_PORT_ALL_INPUTS
                 && cmd_r.bank == IARAO_BANK_DIGITAL) begin
      acc_r <= read_val;
    end else if (exec_arith && cmd_r.typ <= 8'h09 && alu_ok) begin
      acc_r <= alu_result;
    end
  end

  // compare flags
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flags_r <= '0;
    end else if (exec_cmp) begin
      flags_r.zero    <= (acc_r == 32'h0000_0000);
      flags_r.equal   <= (acc_r == cmd_r.value);
      flags_r.greater <= ($signed(acc_r) > $signed(cmd_r.value));
      flags_r.lower   <= ($signed(acc_r) < $signed(cmd_r.value));
    end
  end

  // reply frame and serialiser
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < IARAO_FRAME_BYTES; i++) begin
        frame_r[i] <= 8'h00;
      end
      idx_r         <= IARAO_FIRST_BYTE;
      reply_valid_r <= 1'b0;
      reply_byte_r  <= 8'h00;
    end else if (state_r == IARAO_ST_EXEC && !cmd_r.from_program) begin
      frame_r[0]    <= cmd_r.host_addr;
      frame_r[1]    <= cmd_r.target_addr;
      frame_r[2]    <= status_nxt;
      frame_r[3]    <= cmd_r.instr;
      frame_r[4]    <= value_nxt[31:24];
      frame_r[5]    <= value_nxt[23:16];
      frame_r[6]    <= value_nxt[15:8];
      frame_r[7]    <= value_nxt[7:0];
      frame_r[8]    <= cmd_r.host_addr + cmd_r.target_addr + status_nxt + cmd_r.instr
                       + value_nxt[31:24] + value_nxt[23:16] + value_nxt[15:8]
                       + value_nxt[7:0];
      idx_r         <= IARAO_FIRST_BYTE;
      reply_valid_r <= 1'b1;
      reply_byte_r  <= cmd_r.host_addr;
    end else if (state_r == IARAO_ST_SEND && reply_ready_in) begin
      if (idx_r == IARAO_LAST_BYTE) begin
        reply_valid_r <= 1'b0;
      end else begin
        idx_r        <= idx_r + 4'h1;
        reply_byte_r <= frame_r[idx_r + 4'h1];
      end
    end
  end

  assign chk             = sum_bytes(frame_r);
  assign cmd_ready_out   = cmd_ready_r;
  assign reply_valid_out = reply_valid_r;
  assign reply_byte_out  = reply_byte_r;
  assign prog_done_out   = prog_done_r;
  assign acc_out         = acc_r;
  assign flags_out       = flags_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_gio_prog_acc;
    exec_gio && read_ok && cmd_r.from_program |=> acc_r == $past(read_val);
  endproperty
  a_gio_prog_acc: assert property (p_gio_prog_acc) else $error("program read not in acc");

  property p_gio_direct_keep;
    exec_gio && !cmd_r.from_program && cmd_r.typ != IARAO_PORT_ALL_INPUTS |=> $stable(acc_r);
  endproperty
  a_gio_direct_keep: assert property (p_gio_direct_keep) else $error("direct read moved acc");

  property p_gio_status;
    exec_gio && read_ok && !cmd_r.from_program
      |=> frame_r[2] == IARAO_STATUS_OK && frame_r[7] == $past(read_val[7:0]);
  endproperty
  a_gio_status: assert property (p_gio_status) else $error("bad direct read reply");

  property p_digital_range;
    exec_gio && cmd_r.bank == IARAO_BANK_DIGITAL && cmd_r.typ <= IARAO_PORT_TWO
      |-> read_val <= 32'h0000_0001;
  endproperty
  a_digital_range: assert property (p_digital_range) else $error("digital read out of range");

  property p_analog_range;
    exec_gio && cmd_r.bank == IARAO_BANK_ANALOG && cmd_r.typ == IARAO_PORT_ZERO
      |-> read_val <= IARAO_ANALOG_MAX;
  endproperty
  a_analog_range: assert property (p_analog_range) else $error("analog read out of range");

  property p_arith_write;
    exec_arith && cmd_r.typ <= 8'h09 && alu_ok |=> acc_r == $past(alu_result);
  endproperty
  a_arith_write: assert property (p_arith_write) else $error("arith result not stored");

  property p_arith_reply;
    exec_arith && !cmd_r.from_program
      |=> {frame_r[4], frame_r[5], frame_r[6], frame_r[7]} == $past(cmd_r.value);
  endproperty
  a_arith_reply: assert property (p_arith_reply) else $error("arith reply value wrong");

  property p_cmp_flags;
    exec_cmp |=> flags_r.equal == ($past(acc_r) == $past(cmd_r.value))
      && flags_r.lower == ($signed($past(acc_r)) < $signed($past(cmd_r.value)));
  endproperty
  a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");

  property p_checksum;
    state_r == IARAO_ST_SEND |-> frame_r[8] == chk;
  endproperty
  a_checksum: assert property (p_checksum) else $error("reply checksum wrong");

  property p_first_byte;
    state_r == IARAO_ST_EXEC && !cmd_r.from_program
      |=> reply_valid_out && reply_byte_out == $past(cmd_r.host_addr);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply does not open with host");

  c_direct_gio:  cover property (exec_gio && !cmd_r.from_program);
  c_prog_arith:  cover property (exec_arith && cmd_r.from_program);
  c_compare:     cover property (exec_cmp ##1 flags_r.greater);
  c_reply_done:  cover property (reply_valid_out && reply_ready_in && idx_r == IARAO_LAST_BYTE);
endmodule

// ### tb/iarao_host_model.sv
// host controller model: issues command frames and collects reply bytes
module iarao_host_model (
  // clock
  input  wire logic                     clk_in,
  // command side
  output logic                          cmd_valid_out,
  output iarao_pkg::iarao_cmd_type      cmd_out,
  input  wire logic                     cmd_ready_in,
  // reply side
  input  wire logic                     reply_valid_in,
  input  wire logic [7:0]               reply_byte_in,
  output logic                          reply_ready_out,
  input  wire logic                     prog_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import iarao_pkg::*;
  int slow_pct = 0;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    reply_ready_out = 1'b1;
  end

  // random back-pressure on the reply stream
  always @(posedge clk_in) begin
    reply_ready_out <= ($urandom_range(99) >= slow_pct);
  end

  // compare is only sent with from_program set by the bench
  task automatic issue(input iarao_cmd_type c, output logic [7:0] rep [9]);
    int n;
    int g;
    n = 0;
    g = 0;
    foreach (rep[i]) rep[i] = 8'hXX;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= c;
    do @(negedge clk_in); while (!cmd_ready_in && ++g < 50);
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_out <= ~c;
    while (n < (c.from_program ? 1 : 9) && g < 400) begin
      @(negedge clk_in);
      g++;
      if (c.from_program) begin
        if (prog_done_in) n = 1;
      end else if (reply_valid_in && reply_ready_out) begin
        rep[n] = reply_byte_in;
        n++;
      end
    end
  endtask
endmodule

// ### tb/test_input_read_and_accumulator_ops.sv
// self-checking bench of the input-read and accumulator command block
module test_input_read_and_accumulator_ops;
  timeunit 1ns;
  timeprecision 1ps;
  import iarao_pkg::*;
  logic                     clk_in;
  logic                     reset_in;
  logic                     cmd_valid;
  iarao_cmd_type            cmd;
  logic                     cmd_ready;
  logic [2:0]               gi;
  logic [11:0]              an;
  logic [15:0]              sup;
  logic [15:0]              tmp;
  logic                     general_output_zero;
  logic                     reply_valid;
  logic [7:0]               reply_byte;
  logic                     reply_ready;
  logic                     prog_done;
  logic [31:0]              acc_out;
  iarao_flags_type          flags_out;
  logic [31:0]              acc_m = '0;
  iarao_flags_type          flags_m = '0;
  int                       err_total = 0;
  int                       tests_run = 0;
  logic [15:0]              ports [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0100,
                                          16'h0108, 16'h0109, 16'h0200, 16'h00FF};
  logic [31:0]              cmp_v [4] = '{32'h0000_0064, 32'hFFFF_EC78, 32'h7FFF_FFF0, '0};

  iarao_core u_iarao_core (
    .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_ready_out(cmd_ready), .gen_inputs_in(gi), .analog_zero_in(an),
    .supply_tenths_in(sup), .temperature_in(tmp), .general_output_zero_in(general_output_zero),
    .reply_valid_out(reply_valid), .reply_byte_out(reply_byte), .reply_ready_in(reply_ready),
    .prog_done_out(prog_done), .acc_out(acc_out), .flags_out(flags_out)
  );

  iarao_host_model u_iarao_host_model (
    .clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cmd_ready_in(cmd_ready),
    .reply_valid_in(reply_valid), .reply_byte_in(reply_byte), .reply_ready_out(reply_ready),
    .prog_done_in(prog_done)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic rd(input logic [7:0] b, input logic [7:0] p, output logic [31:0] v);
    rd = 1'b1;
    v = '0;
    if (b == IARAO_BANK_DIGITAL && p <= 8'h02) v = {31'h0, gi[p[1:0]]};
    else if (b == IARAO_BANK_DIGITAL && p == 8'hFF) v = {29'h0, gi};
    else if (b == IARAO_BANK_ANALOG && p == 8'h00) v = {20'h0, an};
    else if (b == IARAO_BANK_ANALOG && p == 8'h08) v = {16'h0, sup};
    else if (b == IARAO_BANK_ANALOG && p == 8'h09) v = {{16{tmp[15]}}, tmp};
    else if (b == IARAO_BANK_OUTPUTS && p == 8'h00) v = {31'h0, general_output_zero};
    else rd = 1'b0;
  endfunction

  function automatic logic accumulator_arith_cmd(input logic [31:0] a, input logic [7:0] op,
                                input logic [31:0] b, output logic [31:0] r);
    accumulator_arith_cmd = 1'b1;
    r = a;
    case (op)
      8'h00: r = a + b;
      8'h01: r = a - b;
      8'h02: r = a * b;
      8'h03: if (b == '0) accumulator_arith_cmd = 1'b0; else r = $signed(a) / $signed(b);
      8'h04: if (b == '0) accumulator_arith_cmd = 1'b0; else r = $signed(a) % $signed(b);
      8'h05: r = a & b;
      8'h06: r = a | b;
      8'h07: r = a ^ b;
      8'h08: r = ~a;
      8'h09: r = b;
      default: accumulator_arith_cmd = 1'b0;
    endcase
  endfunction

  task automatic run(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bnk,
                     input logic [31:0] val, input logic prog);
    iarao_cmd_type c;
    logic [7:0]    rep [9];
    logic [7:0]    st;
    logic [7:0]    sum;
    logic [31:0]   rv;
    logic [31:0]   na;
    c = '{8'($urandom), 8'($urandom), ins, typ, bnk, val, prog};
    st = IARAO_STATUS_OK;
    rv = val;
    na = acc_m;
    if (ins == IARAO_INSTR_GET_INPUT) begin
      if (!rd(bnk, typ, rv)) st = IARAO_STATUS_BAD_VALUE;
      else if (prog || typ == IARAO_PORT_ALL_INPUTS) na = rv;
    end else if (ins == IARAO_INSTR_ARITH) begin
      if (!accumulator_arith_cmd(acc_m, typ, val, na)) st = IARAO_STATUS_BAD_VALUE;
    end else if (ins == IARAO_INSTR_COMPARE) begin
      flags_m = '{acc_m == '0, acc_m == val, $signed(acc_m) > $signed(val),
                  $signed(acc_m) < $signed(val)};
    end else begin
      st = IARAO_STATUS_BAD_CMD;
    end
    acc_m = na;
    u_iarao_host_model.issue(c, rep);
    if (!prog) begin
      sum = '0;
      for (int i = 0; i < 8; i++) sum += rep[i];
      check("host", 32'(rep[0]), 32'(c.host_addr));
      check("target", 32'(rep[1]), 32'(c.target_addr));
      check("status", 32'(rep[2]), 32'(st));
      check("instr", 32'(rep[3]), 32'(ins));
      check("value", {rep[4], rep[5], rep[6], rep[7]}, rv);
      check("checksum", 32'(rep[8]), 32'(sum));
    end
    check("acc", acc_out, acc_m);
    check("flags", {28'h0, flags_out}, {28'h0, flags_m});
    check("ready", 32'(cmd_ready), 32'(prog));
    check("reply valid", 32'(reply_valid), 32'(!prog));
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    conclude();
  end

  initial begin
    void'($urandom(42121));
    reset_in = 1'b1;
    gi = '0;
    an = '0;
    sup = '0;
    tmp = '0;
    general_output_zero = 1'b0;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check("acc reset", acc_out, '0);
    check("flags reset", {28'h0, flags_out}, 32'h0000_0000);
    check("ready reset", 32'(cmd_ready), 32'h0000_0001);
    check("valid reset", 32'(reply_valid), 32'h0000_0000);
    u_iarao_host_model.slow_pct = 40;
    for (int m = 0; m < 2; m++) begin
      foreach (ports[k]) begin
        @(posedge clk_in);
        gi <= 3'($urandom);
        an <= 12'($urandom);
        sup <= 16'($urandom);
        tmp <= 16'($urandom);
        general_output_zero <= 1'($urandom);
        repeat (3) @(posedge clk_in);
        run(IARAO_INSTR_GET_INPUT, ports[k][7:0], ports[k][15:8], 32'($urandom), m[0]);
      end
    end
    $display("test input_reads done");
    for (int op = 0; op < 10; op++) begin
      run(IARAO_INSTR_ARITH, 8'h09, 8'h00, 32'($urandom), 1'b1);
      run(IARAO_INSTR_ARITH, 8'(op), 8'h00, 32'($urandom_range(200)) - 32'd100, op[0]);
    end
    run(IARAO_INSTR_ARITH, 8'h09, 8'h00, 32'h0000_0007, 1'b0);
    run(IARAO_INSTR_ARITH, 8'h02, 8'h00, 32'hFFFF_EC78, 1'b0);
    run(IARAO_INSTR_ARITH, 8'h09, 8'h00, 32'hFFFF_FFF9, 1'b1);
    run(IARAO_INSTR_ARITH, 8'h04, 8'h00, 32'h0000_0002, 1'b1);
    run(IARAO_INSTR_ARITH, 8'h09, 8'h00, 32'hFFFF_FFF9, 1'b1);
    run(IARAO_INSTR_ARITH, 8'h03, 8'h00, 32'h0000_0002, 1'b0);
    run(IARAO_INSTR_ARITH, 8'h03, 8'h00, 32'h0000_0000, 1'b0);
    run(IARAO_INSTR_ARITH, 8'h0A, 8'h00, 32'h0000_0001, 1'b0);
    $display("test arithmetic done");
    u_iarao_host_model.slow_pct = 0;
    foreach (cmp_v[k]) begin
      run(IARAO_INSTR_ARITH, 8'h09, 8'h00, cmp_v[k], 1'b1);
      for (int d = -1; d < 2; d++)
        run(IARAO_INSTR_COMPARE, 8'h00, 8'h00, cmp_v[k] + 32'(d), 1'b1);
    end
    $display("test compare done");
    run(8'h63, 8'h00, 8'h00, 32'h0000_0005, 1'b0);
    run(IARAO_INSTR_GET_INPUT, 8'h00, 8'h03, '0, 1'b0);
    run(IARAO_INSTR_GET_INPUT, 8'h03, 8'h00, '0, 1'b0);
    $display("test refusals done");
    conclude();
  end
endmodule
